// [rtl/usbesc_consts.vh]
// usbesc_consts.vh: constants of the endpoint stall and handshake block
// assumes inclusion by bare name from the block's design files
`ifndef USBESC_CONSTS_VH
`define USBESC_CONSTS_VH
// register byte offsets
`define USBESC_DEV_CTRL_OFS 8'h00
`define USBESC_DEV_STAT_OFS 8'h04
`define USBESC_EP_TYPE_OFS 8'h08
`define USBESC_EP_BASE_OFS 2'h1
`define USBESC_EP_STAT_SUB 2'h0
`define USBESC_EP_CLR_SUB 2'h1
`define USBESC_EP_SET_SUB 2'h2
// field positions
`define USBESC_RMW_BIT 0
`define USBESC_EOR_BIT 0
`define USBESC_IN_RDY_BIT 0
`define USBESC_OUT_RCV_BIT 1
`define USBESC_SETUP_RCV_BIT 2
`define USBESC_STALL_SENT_BIT 3
`define USBESC_READ_WRITE_ALLOWED_BIT 4
`define USBESC_STALL_RQ_BIT 5
`define USBESC_FIFOCTL_BIT 6
`define USBESC_STALL_SET_BIT 0
`define USBESC_STALL_CLR_BIT 1
// reset values
`define USBESC_EP_TYPE_RST 4'h1
`define USBESC_IN_RDY_RST 1'b1
// token types
`define USBESC_TOK_OUT 2'h0
`define USBESC_TOK_IN 2'h1
`define USBESC_TOK_SETUP 2'h2
// handshake answers
`define USBESC_HS_NONE 3'h0
`define USBESC_HS_ACK 3'h1
`define USBESC_HS_NAK 3'h2
`define USBESC_HS_STALL 3'h3
`define USBESC_HS_DATA 3'h4
// timing
`define USBESC_CLK_MHZ 40
`define USBESC_RESUME_US 2000
`define USBESC_RESUME_CYCLES (`USBESC_RESUME_US * `USBESC_CLK_MHZ)
`endif

// [rtl/usbesc_ep_cell.v]
// usbesc_ep_cell: flags and handshake choice of one endpoint
// assumes token hit and firmware strobes are one-cycle pulses on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "usbesc_consts.vh"
module usbesc_ep_cell (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // configuration
   input wire ctrl_ep_i,
   // token from the bus side
   input wire tok_hit_i,
   input wire [1:0] tok_type_i,
   input wire retry_i,
   // firmware strobes
   input wire [3:0] flag_clr_i,
   input wire stall_set_i,
   input wire stall_clr_i,
   // state
   output wire [3:0] flags_o,
   output wire stall_rq_o,
   output reg [2:0] resp_o
);
   reg [3:0] flags_ff;
   reg [3:0] nxt_flags;
   reg stall_rq_ff;
   reg nxt_stall_rq;
   reg [3:0] hw_set;
   wire setup_hit;
   wire need_retry;

   assign flags_o = flags_ff;
   assign stall_rq_o = stall_rq_ff;
   assign setup_hit = tok_hit_i & ctrl_ep_i & (tok_type_i == `USBESC_TOK_SETUP);
   // busy bank or engine retry forces a retry
   assign need_retry = retry_i |
      ((tok_type_i == `USBESC_TOK_OUT) & (flags_ff[`USBESC_OUT_RCV_BIT] | flags_ff[`USBESC_SETUP_RCV_BIT])) |
      ((tok_type_i == `USBESC_TOK_IN) & flags_ff[`USBESC_IN_RDY_BIT]);

   always @* begin
      resp_o = `USBESC_HS_NONE;
      hw_set = 4'h0;
      if (setup_hit) begin
         resp_o = `USBESC_HS_ACK;
         hw_set[`USBESC_SETUP_RCV_BIT] = 1'b1;
      end else if (tok_hit_i && ((tok_type_i == `USBESC_TOK_OUT) || (tok_type_i == `USBESC_TOK_IN))) begin
         if (need_retry) begin
            resp_o = `USBESC_HS_NAK;
         end else if (stall_rq_ff) begin
            resp_o = `USBESC_HS_STALL;
            hw_set[`USBESC_STALL_SENT_BIT] = 1'b1;
         end else if (tok_type_i == `USBESC_TOK_OUT) begin
            resp_o = `USBESC_HS_ACK;
            hw_set[`USBESC_OUT_RCV_BIT] = 1'b1;
         end else begin
            resp_o = `USBESC_HS_DATA;
            hw_set[`USBESC_IN_RDY_BIT] = 1'b1;
         end
      end
   end

   always @* begin
      // hardware set wins over firmware clear
      nxt_flags = (flags_ff & ~flag_clr_i) | hw_set;
      if (setup_hit) begin
         nxt_flags[`USBESC_STALL_SENT_BIT] = 1'b0;
      end
      nxt_stall_rq = stall_rq_ff;
      if (stall_clr_i || setup_hit) begin
         nxt_stall_rq = 1'b0;
      end
      if (stall_set_i) begin
         nxt_stall_rq = 1'b1;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_ff <= {3'h0, `USBESC_IN_RDY_RST};
         stall_rq_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         stall_rq_ff <= nxt_stall_rq;
      end
   end
endmodule // usbesc_ep_cell
`default_nettype wire

// [rtl/usbesc_resume.v]
// usbesc_resume: remote wakeup drive and end-of-resume flag
// assumes end-of-resume detection arrives as a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "usbesc_consts.vh"
module usbesc_resume #(
   parameter RESUME_CYCLES = `USBESC_RESUME_CYCLES
) (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // firmware strobes
   input wire rmw_set_i,
   input wire eor_clr_i,
   // bus side
   input wire eor_det_i,
   // state
   output wire rmw_o,
   output wire resume_drive_o,
   output wire eor_flag_o
);
   reg rmw_ff;
   reg drive_ff;
   reg eor_ff;
   reg [31:0] cnt_ff;
   wire cnt_done;

   assign rmw_o = rmw_ff;
   assign resume_drive_o = drive_ff;
   assign eor_flag_o = eor_ff;
   assign cnt_done = (cnt_ff == 32'h00000001);

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rmw_ff <= 1'b0;
         drive_ff <= 1'b0;
         cnt_ff <= 32'h00000000;
         eor_ff <= 1'b0;
      end else begin
         if (rmw_set_i && !rmw_ff) begin
            rmw_ff <= 1'b1;
            drive_ff <= 1'b1;
            cnt_ff <= RESUME_CYCLES;
         end else if (drive_ff) begin
            cnt_ff <= cnt_ff - 32'h00000001;
            if (cnt_done) begin
               drive_ff <= 1'b0;
               rmw_ff <= 1'b0;
            end
         end
         eor_ff <= eor_det_i | (eor_ff & ~eor_clr_i);
      end
   end
endmodule // usbesc_resume
`default_nettype wire

// [rtl/usbesc_top.v]
// usbesc_top: usb device endpoint stall, setup and bank handshake control
// assumes a protocol engine presents decoded tokens and firmware a simple register port
// Functional notes
// - writing one to an endpoint's stall set bit raises its stall request and stalls the next out or in request that needs no retry.
// - while the stall request stands every following out or in request needing no retry is answered with stall and sets no data flag.
// - the stall request drops on a write of one to stall clear or, on control endpoints, on a new setup.
// - every stall handshake sent sets the stall sent flag and raises the endpoint interrupt.
// - a setup on a stalled control endpoint sets setup received, clears stall request and stall sent, and is acked.
// - a needed retry wins over stall; stall goes out only when requested and no retry is needed.
// - a setup on a control endpoint is always acked and sets setup received while out received is left alone.
// - on control endpoints the fifo control and read write allowed bits always read zero.
// - setup received is set by hardware and cleared by firmware, which frees the bank.
// - out received is set when an out packet is stored and cleared by firmware, which frees the bank.
// - in bank ready is set when an in token is answered with data, freeing the bank, and cleared by firmware to send the next packet.
// - the remote wakeup request bit clears itself when the driven resume has ended.
// - a detected end of resume sets the end of resume flag.
`timescale 1ns/1ps
`default_nettype none
`include "usbesc_consts.vh"
module usbesc_top #(
   parameter NEP = 4,
   parameter RESUME_CYCLES = `USBESC_RESUME_CYCLES
) (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // token from protocol engine
   input wire tok_valid_i,
   input wire [1:0] tok_ep_i,
   input wire [1:0] tok_type_i,
   input wire tok_retry_i,
   // handshake answer
   output reg hs_valid_o,
   output reg [2:0] hs_code_o,
   output reg [1:0] hs_ep_o,
   // interrupts and resume
   output reg [NEP-1:0] endpoint_interrupt_o,
   input wire eor_det_i,
   output wire resume_drive_o
);
   reg [3:0] ep_type_ff;
   wire [3:0] cell_flags [0:NEP-1];
   wire [NEP-1:0] cell_stall_rq;
   wire [2:0] cell_resp [0:NEP-1];
   wire [NEP-1:0] ep_irq;
   wire ep_region;
   wire [1:0] ep_idx;
   wire [1:0] ep_sub;
   wire dev_ctrl_wr;
   wire dev_stat_wr;
   wire rmw;
   wire eor_flag;
   reg [2:0] nxt_code;
   reg [31:0] nxt_rdata;
   reg [6:0] ep_stat;
   integer k;
   integer j;

   assign ep_region = (reg_addr_i[7:6] == `USBESC_EP_BASE_OFS);
   assign ep_idx = reg_addr_i[5:4];
   assign ep_sub = reg_addr_i[3:2];
   assign dev_ctrl_wr = reg_wr_i & (reg_addr_i == `USBESC_DEV_CTRL_OFS);
   assign dev_stat_wr = reg_wr_i & (reg_addr_i == `USBESC_DEV_STAT_OFS);

   genvar g;
   generate
      for (g = 0; g < NEP; g = g + 1) begin : g_ep
         wire sel;
         wire clr_wr;
         wire set_wr;
         assign sel = ep_region & (ep_idx == g);
         assign clr_wr = reg_wr_i & sel & (ep_sub == `USBESC_EP_CLR_SUB);
         assign set_wr = reg_wr_i & sel & (ep_sub == `USBESC_EP_SET_SUB);
         usbesc_ep_cell u_cell (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .ctrl_ep_i(ep_type_ff[g]),
            .tok_hit_i(tok_valid_i & (tok_ep_i == g)),
            .tok_type_i(tok_type_i),
            .retry_i(tok_retry_i),
            .flag_clr_i(clr_wr ? reg_wdata_i[3:0] : 4'h0),
            .stall_set_i(set_wr & reg_wdata_i[`USBESC_STALL_SET_BIT]),
            .stall_clr_i(set_wr & reg_wdata_i[`USBESC_STALL_CLR_BIT]),
            .flags_o(cell_flags[g]),
            .stall_rq_o(cell_stall_rq[g]),
            .resp_o(cell_resp[g])
         );
         assign ep_irq[g] = |cell_flags[g];
      end
   endgenerate

   usbesc_resume #(
      .RESUME_CYCLES(RESUME_CYCLES)
   ) u_resume (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .rmw_set_i(dev_ctrl_wr & reg_wdata_i[`USBESC_RMW_BIT]),
      .eor_clr_i(dev_stat_wr & reg_wdata_i[`USBESC_EOR_BIT]),
      .eor_det_i(eor_det_i),
      .rmw_o(rmw),
      .resume_drive_o(resume_drive_o),
      .eor_flag_o(eor_flag)
   );

   // answer of the addressed endpoint
   always @* begin
      nxt_code = `USBESC_HS_NONE;
      for (k = 0; k < NEP; k = k + 1) begin
         if (tok_ep_i == k) begin
            nxt_code = cell_resp[k];
         end
      end
   end

   // read multiplexer
   always @* begin
      nxt_rdata = 32'h00000000;
      ep_stat = 7'h00;
      for (j = 0; j < NEP; j = j + 1) begin
         if (ep_idx == j) begin
            ep_stat[3:0] = cell_flags[j];
            ep_stat[`USBESC_STALL_RQ_BIT] = cell_stall_rq[j];
            // control endpoints leave both bank bits at zero
            if (!ep_type_ff[j]) begin
               ep_stat[`USBESC_READ_WRITE_ALLOWED_BIT] = cell_flags[j][`USBESC_OUT_RCV_BIT];
               ep_stat[`USBESC_FIFOCTL_BIT] = cell_flags[j][`USBESC_OUT_RCV_BIT];
            end
         end
      end
      if (ep_region) begin
         if (ep_sub == `USBESC_EP_STAT_SUB) begin
            nxt_rdata = {25'h0, ep_stat};
         end
      end else if (reg_addr_i == `USBESC_DEV_CTRL_OFS) begin
         nxt_rdata = {31'h0, rmw};
      end else if (reg_addr_i == `USBESC_DEV_STAT_OFS) begin
         nxt_rdata = {31'h0, eor_flag};
      end else if (reg_addr_i == `USBESC_EP_TYPE_OFS) begin
         nxt_rdata = {28'h0000000, ep_type_ff};
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ep_type_ff <= `USBESC_EP_TYPE_RST;
         reg_rdata_o <= 32'h00000000;
         hs_valid_o <= 1'b0;
         hs_code_o <= `USBESC_HS_NONE;
         hs_ep_o <= 2'h0;
         endpoint_interrupt_o <= {NEP{1'b0}};
      end else begin
         if (reg_wr_i && (reg_addr_i == `USBESC_EP_TYPE_OFS)) begin
            ep_type_ff <= reg_wdata_i[3:0];
         end
         reg_rdata_o <= reg_rd_i ? nxt_rdata : 32'h00000000;
         hs_valid_o <= tok_valid_i & (nxt_code != `USBESC_HS_NONE);
         hs_code_o <= tok_valid_i ? nxt_code : `USBESC_HS_NONE;
         hs_ep_o <= tok_ep_i;
         endpoint_interrupt_o <= ep_irq;
      end
   end
endmodule // usbesc_top
`default_nettype wire

// [verification/usbesc_top_monitor.sv]
// usbesc_top_monitor: assertions on the ports of the stall and handshake block
// assumes ep0 stays the only control endpoint, as after reset
`timescale 1ns/1ps
`default_nettype none
module usbesc_top_monitor #(
   parameter NEP = 4,
   parameter RESUME_CYCLES = 8
) (
   // clock, reset, register port
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // token and answer
   input wire logic tok_valid_i,
   input wire logic [1:0] tok_ep_i,
   input wire logic [1:0] tok_type_i,
   input wire logic tok_retry_i,
   input wire logic hs_valid_o,
   input wire logic [2:0] hs_code_o,
   input wire logic [1:0] hs_ep_o,
   // interrupts and resume
   input wire logic [NEP-1:0] endpoint_interrupt_o,
   input wire logic eor_det_i,
   input wire logic resume_drive_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [31:0] drive_cnt_ff;
   // counts cycles of resume drive
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         drive_cnt_ff <= 32'h0;
      end else if (resume_drive_o) begin
         drive_cnt_ff <= drive_cnt_ff + 32'h1;
      end else begin
         drive_cnt_ff <= 32'h0;
      end
   end
   sequence setup_ep0;
      tok_valid_i && tok_type_i == 2'h2 && tok_ep_i == 2'h0;
   endsequence
   sequence rd_at(logic [7:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   chk_retry_nak: assert property (
      tok_valid_i && tok_retry_i && tok_type_i < 2'h2 && tok_ep_i < NEP |=> hs_valid_o && hs_code_o == 3'h2)
      else $error("retry not answered with nak");
   chk_setup_ack: assert property (setup_ep0 |=> hs_valid_o && hs_code_o == 3'h1)
      else $error("setup not acked");
   chk_stall_irq: assert property (
      hs_valid_o && hs_code_o == 3'h3 |=> endpoint_interrupt_o[$past(hs_ep_o)])
      else $error("stall without endpoint interrupt");
   chk_wo_zero: assert property (
      reg_rd_i && reg_addr_i[7:6] == 2'h1 && reg_addr_i[3:0] == 4'h8 |=> reg_rdata_o == 32'h0)
      else $error("stall set word not zero");
   chk_ctrl_bits: assert property (rd_at(8'h40) |=> !reg_rdata_o[4] && !reg_rdata_o[6])
      else $error("control endpoint bank bits not zero");
   chk_eor_flag: assert property (eor_det_i ##1 !reg_wr_i ##1 rd_at(8'h04) |=> reg_rdata_o[0])
      else $error("end of resume flag not set");
   chk_setup_clears: assert property (
      setup_ep0 ##1 (!tok_valid_i && !reg_wr_i) [*2] ##1 rd_at(8'h40) |=> reg_rdata_o[5:2] == 4'h1)
      else $error("setup left stall state");
   chk_resume_start: assert property (
      reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[0] && !resume_drive_o |=> resume_drive_o)
      else $error("resume drive did not start");
   chk_resume_len: assert property ($fell(resume_drive_o) |-> drive_cnt_ff == RESUME_CYCLES)
      else $error("resume drive length wrong");
endmodule // usbesc_top_monitor
bind usbesc_top usbesc_top_monitor #(.NEP(NEP), .RESUME_CYCLES(RESUME_CYCLES)) u_mon (.*);
`default_nettype wire

// [verification/usbesc_host_model.sv]
// usbesc_host_model: token source standing in for the host and its protocol engine
// assumes the block answers exactly one cycle after taking a token
`timescale 1ns/1ps
`default_nettype none
module usbesc_host_model (
   // clock and answer
   input wire logic clk_i,
   input wire logic hs_valid_i,
   input wire logic [2:0] hs_code_i,
   // token
   output logic tok_valid_o,
   output logic [1:0] tok_ep_o,
   output logic [1:0] tok_type_o,
   output logic tok_retry_o
);
   initial begin
      tok_valid_o = 1'b0;
      tok_ep_o = 2'h0;
      tok_type_o = 2'h0;
      tok_retry_o = 1'b0;
   end
   // one token; qualifiers scrambled once it is gone
   task automatic send(input logic [1:0] ep, input logic [1:0] typ, input logic rt, output logic [2:0] code);
      @(posedge clk_i);
      tok_valid_o <= 1'b1;
      tok_ep_o <= ep;
      tok_type_o <= typ;
      tok_retry_o <= rt;
      @(posedge clk_i);
      tok_valid_o <= 1'b0;
      tok_ep_o <= ~ep;
      tok_type_o <= ~typ;
      tok_retry_o <= ~rt;
      @(posedge clk_i);
      code = hs_valid_i ? hs_code_i : 3'h0;
   endtask
endmodule // usbesc_host_model
`default_nettype wire

// [verification/tb_usbesc_top.sv]
// tb_usbesc_top: self-checking bench of the endpoint stall and handshake block
// assumes a 40 MHz clock and a shortened resume time
`timescale 1ns/1ps
`default_nettype none
module tb_usbesc_top;
   localparam int RC = 8;
   logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, eor_det_i, tok_valid_i, tok_retry_i, hs_valid_o, resume_drive_o;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   logic [1:0] tok_ep_i, tok_type_i, hs_ep_o;
   logic [2:0] hs_code_o, c;
   logic [3:0] endpoint_interrupt_o;
   int failures = 0, comparisons = 0, cyc = 0, i;
   // rows: ep, type, retry, expected answer
   logic [7:0] rows [7] = '{8'h41, 8'h42, 8'h21, 8'h54, 8'hCA, 8'h60, 8'h30};
   usbesc_top #(.NEP(4), .RESUME_CYCLES(RC)) dut (.*);
   usbesc_host_model host (.clk_i(clk_i), .hs_valid_i(hs_valid_o), .hs_code_i(hs_code_o),
      .tok_valid_o(tok_valid_i), .tok_ep_o(tok_ep_i), .tok_type_o(tok_type_i), .tok_retry_o(tok_retry_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic print_verdict();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
      chk(reg_rdata_o, exp);
   endtask
   task automatic tk(input logic [1:0] ep, input logic [1:0] typ, input logic rt, input logic [2:0] exp);
      host.send(ep, typ, rt, c);
      chk({29'h0, c}, {29'h0, exp});
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      {reg_wr_i, reg_rd_i, eor_det_i, reg_addr_i, reg_wdata_i} = '0;
      sys_rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({28'h0, endpoint_interrupt_o}, 32'hF);
      rd(8'h08, 32'h1);
      rd(8'h30, 32'h0);
      wr(8'h54, 32'h1);
      for (i = 0; i < 7; i++) begin
         tk(rows[i][7:6], rows[i][5:4], rows[i][3], rows[i][2:0]);
      end
      rd(8'h50, 32'h53);
      wr(8'h54, 32'h2);
      rd(8'h50, 32'h1);
      rd(8'h40, 32'h5);
      wr(8'h44, 32'hF);
      rd(8'h40, 32'h0);
      wr(8'h64, 32'h1);
      wr(8'h68, 32'h0);
      rd(8'h60, 32'h0);
      chk({31'h0, endpoint_interrupt_o[2]}, 32'h0);
      wr(8'h68, 32'h1);
      rd(8'h60, 32'h20);
      tk(2'h2, 2'h0, 1'b0, 3'h3);
      tk(2'h2, 2'h0, 1'b0, 3'h3);
      chk({31'h0, endpoint_interrupt_o[2]}, 32'h1);
      rd(8'h60, 32'h28);
      tk(2'h2, 2'h0, 1'b1, 3'h2);
      rd(8'h68, 32'h0);
      wr(8'h68, 32'h2);
      rd(8'h60, 32'h8);
      tk(2'h2, 2'h0, 1'b0, 3'h1);
      wr(8'h48, 32'h1);
      tk(2'h0, 2'h0, 1'b0, 3'h3);
      tk(2'h0, 2'h2, 1'b0, 3'h1);
      rd(8'h40, 32'h4);
      wr(8'h00, 32'h1);
      @(posedge clk_i);
      chk({31'h0, resume_drive_o}, 32'h1);
      repeat (RC + 2) @(posedge clk_i);
      chk({31'h0, resume_drive_o}, 32'h0);
      rd(8'h00, 32'h0);
      @(posedge clk_i);
      eor_det_i <= 1'b1;
      @(posedge clk_i);
      eor_det_i <= 1'b0;
      rd(8'h04, 32'h1);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h0);
      print_verdict();
   end
endmodule // tb_usbesc_top
`default_nettype wire
